// ===== rtl/rcb_defines.svh
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define RCB_ADDR_PIN_ROUTE 16'h1C00
`define RCB_ADDR_BOOT_MODE 16'h1C5A
`define RCB_PIN_ROUTE_RESET 16'h103F
`define RCB_PIN_ROUTE_WMASK 16'hFF3F
`define RCB_UNMAPPED_READ 16'h0000

// ****************************************************************
// field layout
// ****************************************************************
`define RCB_UPPER_LSB 0
`define RCB_UPPER_MSB 5
`define RCB_UPPER_W 6
`define RCB_ADDR_W 21
`define RCB_LOW_ADDR_W 15

// ****************************************************************
// timing in system clock cycles
// ****************************************************************
`define RCB_RESET_MIN_P 3
`define RCB_PIN_HOLD_P 2
`define RCB_CAPTURE_P 10
`define RCB_CNT_W 4

`endif

// ===== rtl/rcb_pkg.sv
`default_nettype none

package rcb_pkg;

  // clock source feeding the system clock
  typedef enum logic [1:0] {
    RCB_SRC_GEN_USB_OSC,
    RCB_SRC_GEN_EXT,
    RCB_SRC_BYPASS_EXT,
    RCB_SRC_BYPASS_RTC
  } rcb_clk_src_t;

  // straps held from the last reset
  typedef struct packed {
    logic core_reg_en;
    logic clk_sel;
  } rcb_strap_t;

  // processor i/o access
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rcb_io_req_t;

  // phase after the internal reset
  typedef enum logic [1:0] {
    RCB_PH_RESET,
    RCB_PH_WAIT,
    RCB_PH_DONE
  } rcb_phase_t;

endpackage

`default_nettype wire

// ===== rtl/rcb_top.sv
`include "rcb_defines.svh"

`default_nettype none

// What this block does
// - in deep idle the clock bypasses generator: external clock or rtc.
// - regulator strap 0: internal reset is supply good AND reset pin.
// - regulator strap 1: supply good forced high, pin is sole reset.
// - clock strap 0: usb oscillator drives generator, usb regulator on.
// - clock strap 1: external clock drives it, usb enables cleared.
// - during reset the six upper address pins are general inputs.
// - ten clocks after reset rise, boot pins latch into readable register.
// - boot code reads the latched boot mode to pick its source.
// - boot code writes route select to make pins address outputs.
// - address pins switched give 21-bit reach instead of 15-bit.
// - nand and sdram boot need not switch upper address pins.
// - no boot straight into external memory; its clock is stopped.
// - six upper address pins high impedance during reset and two clocks after.
module rcb_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins and analog monitor, asynchronous
  input wire logic reset_pin_n,
  input wire logic supply_good_raw,
  input wire logic core_regulator_enable_strap,
  input wire logic clock_select_strap,
  input wire logic [5:0] general_io_line_in,
  // processor side, same clock
  input wire rcb_pkg::rcb_io_req_t io_req,
  input wire logic deep_idle_state,
  input wire logic usb_osc_set,
  input wire logic usb_reg_set,
  input wire logic ext_mem_clock_stop,
  input wire logic [20:0] mem_addr,
  // resets and clock control
  output logic hw_reset_n,
  output logic supply_good,
  output rcb_pkg::rcb_clk_src_t system_clock_src,
  output logic usb_osc_enable,
  output logic usb_regulator_enable,
  output logic ext_mem_clock_en,
  // pad control
  output logic pins_released,
  output logic [5:0] general_io_line_oe,
  output logic [5:0] general_io_line_out,
  output logic [20:0] ext_addr_out,
  // register reads
  output logic [15:0] io_rdata,
  output logic io_rvalid
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;

  // two stages for every asynchronous input
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      // core enable sits above clock select, as in the strap struct
      sync1_reg <= {general_io_line_in, core_regulator_enable_strap,
                    clock_select_strap, supply_good_raw,
                    reset_pin_n};
      sync2_reg <= sync1_reg;
    end
  end

  logic pin_s;
  logic good_s;
  rcb_pkg::rcb_strap_t strap_s;
  logic [5:0] boot_s;
  assign pin_s = sync2_reg[0];
  assign good_s = sync2_reg[1];
  assign strap_s = rcb_pkg::rcb_strap_t'(sync2_reg[3:2]);
  assign boot_s = sync2_reg[9:4];

  // ****************************************************************
  // reset formation
  // ****************************************************************
  logic [3:0] low_cnt_reg;
  logic pin_valid_reg;
  logic good_next;

  // a low pulse counts only after the minimum width
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_cnt_reg <= '0;
      pin_valid_reg <= 1'b0;
    end else if (pin_s) begin
      low_cnt_reg <= '0;
      pin_valid_reg <= 1'b1;
    end else if (low_cnt_reg < 4'(`RCB_RESET_MIN_P - 1)) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end else begin
      pin_valid_reg <= 1'b0;
    end
  end

  // monitor bypassed when the core regulator enable strap is high
  assign good_next = strap_s.core_reg_en ? 1'b1 : good_s;

  // internal reset is the AND of supply good and the pin
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supply_good <= 1'b0;
      hw_reset_n <= 1'b0;
    end else begin
      supply_good <= good_next;
      hw_reset_n <= good_next & pin_valid_reg;
    end
  end

  logic in_reset;
  assign in_reset = !rst_n || !hw_reset_n;

  // ****************************************************************
  // strap capture and clock source
  // ****************************************************************
  rcb_pkg::rcb_strap_t strap_reg;

  // straps are sampled only while reset is applied
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_reg <= '0;
    end else if (!hw_reset_n) begin
      strap_reg <= strap_s;
    end
  end

  // select generator input or bypass source
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      system_clock_src <= rcb_pkg::RCB_SRC_GEN_USB_OSC;
    end else if (deep_idle_state) begin
      system_clock_src <= strap_reg.clk_sel ? rcb_pkg::RCB_SRC_BYPASS_EXT
                                            : rcb_pkg::RCB_SRC_BYPASS_RTC;
    end else if (strap_reg.clk_sel) begin
      system_clock_src <= rcb_pkg::RCB_SRC_GEN_EXT;
    end else begin
      system_clock_src <= rcb_pkg::RCB_SRC_GEN_USB_OSC;
    end
  end

  // usb enables follow the strap at reset, software may set later
  always_ff @(posedge clock) begin
    if (in_reset) begin
      usb_osc_enable <= !strap_s.clk_sel;
      usb_regulator_enable <= !strap_s.clk_sel;
    end else begin
      if (usb_osc_set) begin
        usb_osc_enable <= 1'b1;
      end
      if (usb_reg_set) begin
        usb_regulator_enable <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // post reset sequencing and boot mode capture
  // ****************************************************************
  rcb_pkg::rcb_phase_t phase_reg;
  logic [`RCB_CNT_W-1:0] cyc_reg;
  logic [15:0] boot_mode_capture_reg;

  // true in the cycle whose edge latches the boot pins
  function automatic logic capture_due(input logic [`RCB_CNT_W-1:0] c);
    capture_due = (c == `RCB_CNT_W'(`RCB_CAPTURE_P - 1));
  endfunction

  // count cycles after reset rise, latch exactly once
  always_ff @(posedge clock) begin
    if (in_reset) begin
      phase_reg <= rcb_pkg::RCB_PH_WAIT;
      cyc_reg <= '0;
      pins_released <= 1'b0;
    end else begin
      case (phase_reg)
        rcb_pkg::RCB_PH_WAIT: begin
          cyc_reg <= cyc_reg + `RCB_CNT_W'(1);
          if (cyc_reg == `RCB_CNT_W'(`RCB_PIN_HOLD_P - 1)) begin
            pins_released <= 1'b1;
          end
          if (capture_due(cyc_reg)) begin
            phase_reg <= rcb_pkg::RCB_PH_DONE;
          end
        end
        default: begin
          phase_reg <= rcb_pkg::RCB_PH_DONE;
        end
      endcase
    end
  end

  // capture register holds its value until the capture after the next hardware reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boot_mode_capture_reg <= '0;
    end else if (!in_reset && phase_reg == rcb_pkg::RCB_PH_WAIT &&
                 capture_due(cyc_reg)) begin
      boot_mode_capture_reg <= {10'h000, boot_s};
    end
  end

  // ****************************************************************
  // pin route register
  // ****************************************************************
  logic [15:0] pin_route_select_reg;

  // upper address lines default to general inputs at reset
  always_ff @(posedge clock) begin
    if (in_reset) begin
      pin_route_select_reg <= `RCB_PIN_ROUTE_RESET;
    end else if (io_req.wr && io_req.addr == `RCB_ADDR_PIN_ROUTE) begin
      pin_route_select_reg <= io_req.wdata & `RCB_PIN_ROUTE_WMASK;
    end
  end

  // read decode, unmapped addresses return zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      io_rdata <= '0;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_req.rd;
      if (!io_req.rd) begin
        io_rdata <= `RCB_UNMAPPED_READ;
      end else if (io_req.addr == `RCB_ADDR_PIN_ROUTE) begin
        io_rdata <= pin_route_select_reg;
      end else if (io_req.addr == `RCB_ADDR_BOOT_MODE) begin
        io_rdata <= boot_mode_capture_reg;
      end else begin
        io_rdata <= `RCB_UNMAPPED_READ;
      end
    end
  end

  // ****************************************************************
  // address pad drive
  // ****************************************************************
  logic [5:0] addr_mode;
  assign addr_mode = pin_route_select_reg[`RCB_UPPER_MSB:`RCB_UPPER_LSB];

  // a line drives only after release and when routed to address use
  always_ff @(posedge clock) begin
    if (in_reset) begin
      general_io_line_oe <= '0;
      general_io_line_out <= '0;
      ext_addr_out <= '0;
    end else begin
      general_io_line_oe <= pins_released ? ~addr_mode : '0;
      general_io_line_out <= mem_addr[`RCB_ADDR_W-1:`RCB_LOW_ADDR_W];
      ext_addr_out <= {mem_addr[`RCB_ADDR_W-1:`RCB_LOW_ADDR_W] & ~addr_mode,
                       mem_addr[`RCB_LOW_ADDR_W-1:0]};
    end
  end

  // memory port clock stops before the jump to loaded code
  always_ff @(posedge clock) begin
    if (in_reset) begin
      ext_mem_clock_en <= 1'b1;
    end else if (ext_mem_clock_stop) begin
      ext_mem_clock_en <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== test/rcb_props.sv
`default_nettype none
module rcb_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // watched ports
  input wire logic clock_select_strap,
  input wire logic core_regulator_enable_strap,
  input wire rcb_pkg::rcb_io_req_t io_req,
  input wire logic deep_idle_state,
  input wire logic hw_reset_n,
  input wire logic supply_good,
  input wire rcb_pkg::rcb_clk_src_t system_clock_src,
  input wire logic usb_regulator_enable,
  input wire logic pins_released,
  input wire logic [5:0] general_io_line_oe,
  input wire logic [15:0] io_rdata,
  input wire logic io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // pads stay quiet two cycles after the internal reset lifts
  sequence s_rel;
    !pins_released ##1 !pins_released ##[1:2] pins_released;
  endsequence
  // pad registers follow the internal reset one edge later
  a_hiz_in_reset: assert property (!hw_reset_n |=>
    !pins_released && general_io_line_oe == 6'h00)
    else $error("pads enabled during reset");
  a_release_late: assert property ($rose(hw_reset_n) |-> s_rel)
    else $error("pads released at wrong time");
  a_supply_forced: assert property (
    core_regulator_enable_strap [*6] |-> supply_good)
    else $error("supply good not forced");
  a_reset_and: assert property (
    !supply_good |-> ##[0:1] !hw_reset_n)
    else $error("reset not held by supply");
  a_usb_off: assert property (
    (clock_select_strap && !hw_reset_n) [*6] |-> !usb_regulator_enable)
    else $error("usb regulator on with strap one");
  a_usb_on: assert property (
    (!clock_select_strap && !hw_reset_n) [*6] |-> usb_regulator_enable)
    else $error("usb regulator off with strap zero");
  a_idle_bypass: assert property (
    (deep_idle_state && hw_reset_n) [*2] |-> system_clock_src ==
    (clock_select_strap ? rcb_pkg::RCB_SRC_BYPASS_EXT
                        : rcb_pkg::RCB_SRC_BYPASS_RTC))
    else $error("deep idle source wrong");
  a_read_pulse: assert property (io_req.rd && hw_reset_n |=>
    io_rvalid ##1 !io_rvalid || $past(io_req.rd))
    else $error("read answer not one cycle");
  a_unmapped_zero: assert property (io_req.rd &&
    io_req.addr != 16'h1c00 && io_req.addr != 16'h1c5a |=>
    io_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== test/rcb_board.sv
`default_nettype none
module rcb_board (
  // clock
  input wire logic clock,
  // straps, reset and boot terminations
  output logic reset_pin_n,
  output logic supply_good_raw,
  output logic core_regulator_enable_strap,
  output logic clock_select_strap,
  output logic [5:0] boot_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // power up with reset held
  initial begin
    reset_pin_n = 1'b0;
    supply_good_raw = 1'b1;
    core_regulator_enable_strap = 1'b0;
    clock_select_strap = 1'b0;
    boot_pins = 6'h2a;
  end
  // straps move only while the reset pin is low
  task automatic pulse(input logic core, csel, sup, input logic [5:0] m,
    input int n);
    @(negedge clock);
    reset_pin_n = 1'b0;
    core_regulator_enable_strap = core;
    clock_select_strap = csel;
    supply_good_raw = sup;
    boot_pins = m;
    repeat (n) @(negedge clock);
    reset_pin_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, reset_pin_n, supply_good_raw, deep_idle_state;
  logic core_regulator_enable_strap, clock_select_strap, usb_osc_set;
  logic usb_reg_set, ext_mem_clock_stop, hw_reset_n, supply_good;
  logic usb_osc_enable, usb_regulator_enable, ext_mem_clock_en;
  logic pins_released, io_rvalid;
  logic [5:0] boot_pins, general_io_line_oe, general_io_line_out;
  logic [20:0] mem_addr, ext_addr_out;
  logic [15:0] io_rdata;
  rcb_pkg::rcb_io_req_t io_req;
  rcb_pkg::rcb_clk_src_t system_clock_src;
  int n_errors, comparisons;
  // pin level: device where enabled, board terminations elsewhere
  wire logic [5:0] general_io_line_in = (general_io_line_oe &
    general_io_line_out) | (~general_io_line_oe & boot_pins);
  rcb_board rcb_board_inst (.*);
  rcb_top rcb_top_inst (.*);
  // free running clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [20:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic io_wr(input logic [15:0] a, d);
    @(negedge clock);
    io_req = '{a, d, 1'b1, 1'b0};
    @(negedge clock);
    io_req = '0;
  endtask
  task automatic rd_chk(input logic [15:0] a, exp);
    @(negedge clock);
    io_req = '{a, 16'h0000, 1'b0, 1'b1};
    @(negedge clock);
    io_req = '0;
    check(io_rvalid, 1'b1);
    check(io_rdata, exp);
  endtask
  task automatic wait_hw(input logic v);
    for (int i = 0; i < 60 && hw_reset_n !== v; i++) @(negedge clock);
    if (hw_reset_n !== v) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic boot(input logic core, csel, sup, input logic [5:0] m);
    rcb_board_inst.pulse(core, csel, sup, m, 6);
    wait_hw(1'b1);
    repeat (12) @(negedge clock);
  endtask
  // one-cycle strobe on {memory clock stop, usb reg set, usb osc set}
  task automatic pulse_in(input logic [2:0] sel);
    @(negedge clock);
    {ext_mem_clock_stop, usb_reg_set, usb_osc_set} = sel;
    @(negedge clock);
    {ext_mem_clock_stop, usb_reg_set, usb_osc_set} = 3'h0;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_n, deep_idle_state, usb_osc_set, usb_reg_set} = '0;
    ext_mem_clock_stop = 1'b0;
    io_req = '0;
    mem_addr = 21'h1a_9234;
    n_errors = 0;
    comparisons = 0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    boot(1'b0, 1'b0, 1'b1, 6'h2a);
    check(usb_regulator_enable, 1'b1);
    check(system_clock_src, rcb_pkg::RCB_SRC_GEN_USB_OSC);
    check(pins_released, 1'b1);
    check(general_io_line_oe, 6'h00);
    rd_chk(16'h1c5a, 16'h002a);
    rd_chk(16'h1c00, 16'h103f);
    rcb_board_inst.boot_pins = 6'h15;
    io_wr(16'h1c5a, 16'hffff);
    rd_chk(16'h1c5a, 16'h002a);
    rd_chk(16'h1c02, 16'h0000);
    io_wr(16'h1c00, 16'hffc0);
    rd_chk(16'h1c00, 16'hff00);
    check(general_io_line_oe, 6'h3f);
    check(general_io_line_out, 6'h35);
    check(ext_addr_out, 21'h1a_9234);
    io_wr(16'h1c00, 16'h103f);
    repeat (2) @(negedge clock);
    check(ext_addr_out, 21'h00_1234);
    check(ext_mem_clock_en, 1'b1);
    pulse_in(3'h4);
    repeat (2) @(negedge clock);
    check(ext_mem_clock_en, 1'b0);
    deep_idle_state = 1'b1;
    repeat (3) @(negedge clock);
    check(system_clock_src, rcb_pkg::RCB_SRC_BYPASS_RTC);
    deep_idle_state = 1'b0;
    rcb_board_inst.pulse(1'b0, 1'b0, 1'b1, 6'h15, 2);
    repeat (8) @(negedge clock);
    check(hw_reset_n, 1'b1);
    boot(1'b1, 1'b1, 1'b0, 6'h0c);
    check(supply_good, 1'b1);
    check(usb_regulator_enable, 1'b0);
    check(usb_osc_enable, 1'b0);
    check(system_clock_src, rcb_pkg::RCB_SRC_GEN_EXT);
    rd_chk(16'h1c5a, 16'h000c);
    pulse_in(3'h2);
    pulse_in(3'h1);
    check({usb_regulator_enable, usb_osc_enable}, 2'b11);
    deep_idle_state = 1'b1;
    repeat (3) @(negedge clock);
    check(system_clock_src, rcb_pkg::RCB_SRC_BYPASS_EXT);
    deep_idle_state = 1'b0;
    rcb_board_inst.pulse(1'b0, 1'b1, 1'b0, 6'h0c, 6);
    repeat (20) @(negedge clock);
    check(hw_reset_n, 1'b0);
    check(pins_released, 1'b0);
    rcb_board_inst.supply_good_raw = 1'b1;
    wait_hw(1'b1);
    tally_and_finish();
  end
endmodule
bind rcb_top rcb_props rcb_props_inst (.clock, .rst_n, .clock_select_strap,
  .core_regulator_enable_strap, .io_req, .deep_idle_state, .hw_reset_n,
  .supply_good, .system_clock_src, .usb_regulator_enable, .pins_released,
  .general_io_line_oe, .io_rdata, .io_rvalid);
`default_nettype wire
